//--- rtl/ias_consts.svh
// Constants of the two-wire register access slave: addresses, fields, resets, timing
`ifndef IAS_CONSTS_SVH
`define IAS_CONSTS_SVH
// Bus address, seven bits, direction bit appended below it
`define IAS_SLAVE_ADDR 7'h58
// Register indices
`define IAS_REG_STR1 4'h0
`define IAS_REG_STR2 4'h1
`define IAS_REG_STR3 4'h2
`define IAS_REG_STR4 4'h3
`define IAS_REG_VREG 4'h4
`define IAS_REG_DRN1 4'h5
`define IAS_REG_DRN2 4'h6
`define IAS_REG_DRN3 4'h7
`define IAS_REG_DRN4 4'h8
`define IAS_REG_VOUT 4'h9
`define IAS_REG_FAULT 4'ha
`define IAS_REG_HOLD 4'hb
`define IAS_REG_REV 4'hc
`define IAS_REG_LAST 4'hc
// Field positions
`define IAS_FLT_OV_BIT 0
`define IAS_FLT_SHORT_LSB 2
`define IAS_HOLD_BIT 0
`define IAS_ADC_TMO_BIT 7
// Converter channel codes
`define IAS_ADC_CH_VOUT 3'h4
// Reset values
`define IAS_RST7 7'h00
`define IAS_RST8 8'h00
`define IAS_RST6 6'h00
// Revision code, value is arbitrary
`define IAS_REVISION 3'h1
// Spike filter: least stable time in ns, clock in MHz, cycles rounded up
`define IAS_MCLK_MHZ 40
`define IAS_SPIKE_NS 50
`define IAS_FILT_CYC ((`IAS_SPIKE_NS * `IAS_MCLK_MHZ + 999) / 1000)
`endif

//--- rtl/ias_pkg.sv
// Types of the two-wire register access slave
package ias_pkg;
  // Protocol states, Gray coded along the usual path
  typedef enum logic [3:0] {
    IAS_IDLE = 4'h0,
    IAS_ADDR = 4'h1,
    IAS_ADDR_ACK = 4'h3,
    IAS_CMD = 4'h2,
    IAS_CMD_ACK = 4'h6,
    IAS_WR = 4'h7,
    IAS_WR_ACK = 4'h5,
    IAS_RD = 4'h4,
    IAS_RD_ACK = 4'hc
  } ias_state_t;
  typedef logic [3:0] ias_ptr_t;
endpackage

//--- rtl/ias_line_filter.sv
// Two-flop synchroniser and spike filter for one bus line
`timescale 1ns/100ps
`include "ias_consts.svh"
module ias_line_filter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Raw line and filtered level
  input wire logic line_in,
  output logic line_filt
);
  localparam logic [3:0] FILT_M1 = 4'(`IAS_FILT_CYC - 1);
  logic sync1, sync2;
  logic [3:0] cnt, next_cnt;
  logic next_filt;

  // Level follows only after it stood for the filter time
  always_comb begin
    next_cnt = cnt;
    next_filt = line_filt;
    if (sync2 == line_filt) begin
      next_cnt = 4'h0;
    end else if (cnt == FILT_M1) begin
      next_filt = sync2; // RULE15
      next_cnt = 4'h0;
    end else begin
      next_cnt = cnt + 4'h1;
    end
  end

  // Synchroniser and filter registers, idle bus is high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      cnt <= 4'h0;
      line_filt <= 1'b1;
    end else begin
      sync1 <= line_in; // RULE26
      sync2 <= sync1;
      cnt <= next_cnt;
      line_filt <= next_filt;
    end
  end

  a_spike_reject: assert property (@(posedge mclk) disable iff (rst) // RULE15
    $changed(line_filt) |-> $past(sync2, 1) == line_filt && $past(sync2, 2) == line_filt)
    else $error("filtered line changed before input stood long enough");
endmodule

//--- rtl/ias_slave.sv
// Two-wire register access slave of the LED driver with its register file
// Behaviour
// RULE1 - Answer only when the seven address bits after START equal 58h.
// RULE2 - Address byte B1h means read, B0h means write; low bit is direction.
// RULE3 - Slave only; the master makes every clock and starts every transfer.
// RULE4 - Hold data low through the ninth clock after a matching address.
// RULE5 - Master makes START and STOP by data edges while clock is high.
// RULE6 - Bytes move most significant bit first, one bit per clock.
// RULE7 - Data changes only while clock is low; change in high is START/STOP.
// RULE8 - Receiver pulls data low on ninth clock; high there is not-acknowledge.
// RULE9 - Write: START, address write, command, data bytes, each acked, STOP.
// RULE10 - Command byte is the register address; invalid one gets not-acknowledge.
// RULE11 - Written byte goes to pointed register; pointer advances, wraps.
// RULE12 - Read: command written, repeated START, address read, master acks.
// RULE13 - Read sends pointed register; pointer advances after each byte, wraps.
// RULE14 - When busy or out of map, no ack and pointer stays unchanged.
// RULE15 - Clock and data inputs filtered against short spikes.
// RULE16 - Each drain channel register: seven result bits plus timeout bit.
// RULE17 - Drain conversions arrive in sequence, each into its own register.
// RULE18 - Regulator output lowered only, through a seven-bit setting.
// RULE19 - String setting lowers sink reference from 316mV by 1.72mV steps.
// RULE20 - Shorted string and overvoltage faults recorded in fault register.
// RULE21 - Writing one to the standby register enters standby.
// RULE22 - Standby is bit 0 of 0Bh; one enters standby, zero leaves.
// RULE23 - Fault register: bit 0 overvoltage, bits 2-5 shorts; cleared by read.
// RULE24 - Regulator reference is 1.25V minus 2.91mV per setting step.
// RULE25 - Map ends at revision register 0Ch; pointer wraps after it.
// RULE26 - Lines sampled into the clock domain before edge and frame detection.
`timescale 1ns/100ps
`include "ias_consts.svh"
module ias_slave (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus lines, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Device busy, command refused while high
  input wire logic busy,
  // Converter results
  input wire logic adc_load,
  input wire logic [2:0] adc_chan,
  input wire logic [7:0] adc_data,
  // Fault events
  input wire logic reg_overvolt_event,
  input wire logic [3:0] string_short_event,
  // Settings to the analog side
  output logic [6:0] string1_current_setting,
  output logic [6:0] string2_current_setting,
  output logic [6:0] string3_current_setting,
  output logic [6:0] string4_current_setting,
  output logic [6:0] regulator_setting,
  output logic low_power_hold
);
  logic scl_f, sda_f, s_prev, d_prev;
  logic start_c, stop_c, rise, fall;
  ias_pkg::ias_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, rd_val;
  logic rw, next_rw, mack, next_mack, next_oe_n, rd_clr;
  ias_pkg::ias_ptr_t ptr, next_ptr;
  logic [6:0] cur [0:3];
  logic [6:0] next_cur [0:3];
  logic [6:0] vreg, next_vreg, vout, next_vout;
  logic [7:0] drn [0:3];
  logic [7:0] next_drn [0:3];
  logic [5:0] fault, next_fault, ev_now, ev_prev;
  logic hold, next_hold;

  // Pointer advance with wrap after the last register
  function automatic ias_pkg::ias_ptr_t ptr_inc(input ias_pkg::ias_ptr_t p);
    return (p == `IAS_REG_LAST) ? 4'h0 : p + 4'h1;
  endfunction

  // Command inside the register map
  function automatic logic cmd_ok(input logic [7:0] c);
    return c <= {4'h0, `IAS_REG_LAST};
  endfunction

  // Line filters, synchronised levels only
  ias_line_filter u_scl (
    .mclk(mclk),
    .rst(rst),
    .line_in(scl_in),
    .line_filt(scl_f)
  );
  ias_line_filter u_sda (
    .mclk(mclk),
    .rst(rst),
    .line_in(sda_in),
    .line_filt(sda_f)
  );

  // Frame and clock edge detection on filtered levels
  assign start_c = s_prev & scl_f & d_prev & ~sda_f; // RULE5 RULE26
  assign stop_c = s_prev & scl_f & ~d_prev & sda_f; // RULE5
  assign rise = ~s_prev & scl_f; // RULE3
  assign fall = s_prev & ~scl_f; // RULE7
  assign ev_now = {string_short_event, 1'b0, reg_overvolt_event};

  // Settings driven straight from their registers
  assign string1_current_setting = cur[0]; // RULE19
  assign string2_current_setting = cur[1];
  assign string3_current_setting = cur[2];
  assign string4_current_setting = cur[3];
  assign regulator_setting = vreg; // RULE18 RULE24
  assign low_power_hold = hold; // RULE22

  // Read data of the pointed register
  always_comb begin
    rd_val = 8'h00;
    case (ptr)
      `IAS_REG_STR1, `IAS_REG_STR2, `IAS_REG_STR3, `IAS_REG_STR4: begin
        rd_val = {1'b0, cur[ptr[1:0]]};
      end
      `IAS_REG_VREG: rd_val = {1'b0, vreg};
      `IAS_REG_DRN1: rd_val = drn[0]; // RULE16
      `IAS_REG_DRN2: rd_val = drn[1];
      `IAS_REG_DRN3: rd_val = drn[2];
      `IAS_REG_DRN4: rd_val = drn[3];
      `IAS_REG_VOUT: rd_val = {1'b0, vout};
      `IAS_REG_FAULT: rd_val = {2'b00, fault}; // RULE23
      `IAS_REG_HOLD: rd_val = {7'h00, hold};
      `IAS_REG_REV: rd_val = {5'h00, `IAS_REVISION}; // RULE25
      default: rd_val = 8'h00;
    endcase
  end

  // Protocol engine, register writes, converter results and faults
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_rw = rw;
    next_mack = mack;
    next_oe_n = sda_oe_n;
    next_ptr = ptr;
    next_cur = cur;
    next_vreg = vreg;
    next_vout = vout;
    next_drn = drn;
    next_hold = hold;
    rd_clr = 1'b0;
    if (stop_c) begin
      next_state = ias_pkg::IAS_IDLE;
      next_oe_n = 1'b1;
    end else if (start_c) begin
      next_state = ias_pkg::IAS_ADDR; // RULE12
      next_cnt = 4'h0;
      next_oe_n = 1'b1;
    end else begin
      unique case (state)
        ias_pkg::IAS_IDLE: ;
        ias_pkg::IAS_ADDR: begin
          if (rise) begin
            next_sh = {sh[6:0], sda_f}; // RULE6
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == 4'h8) begin
            if (sh[7:1] == `IAS_SLAVE_ADDR) begin // RULE1
              next_rw = sh[0]; // RULE2
              next_oe_n = 1'b0; // RULE4
              next_state = ias_pkg::IAS_ADDR_ACK;
            end else begin
              next_state = ias_pkg::IAS_IDLE;
            end
          end
        end
        ias_pkg::IAS_ADDR_ACK: begin
          if (fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              next_sh = rd_val; // RULE13
              next_oe_n = rd_val[7]; // RULE6
              next_state = ias_pkg::IAS_RD;
            end else begin
              next_oe_n = 1'b1;
              next_state = ias_pkg::IAS_CMD;
            end
          end
        end
        ias_pkg::IAS_CMD: begin
          if (rise) begin
            next_sh = {sh[6:0], sda_f};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == 4'h8) begin
            if (cmd_ok(sh) && !busy) begin
              next_ptr = sh[3:0]; // RULE10
              next_oe_n = 1'b0; // RULE8
              next_state = ias_pkg::IAS_CMD_ACK;
            end else begin
              next_oe_n = 1'b1; // RULE14
              next_state = ias_pkg::IAS_IDLE;
            end
          end
        end
        ias_pkg::IAS_CMD_ACK, ias_pkg::IAS_WR_ACK: begin
          if (fall) begin
            next_oe_n = 1'b1;
            next_cnt = 4'h0;
            next_state = ias_pkg::IAS_WR; // RULE9
          end
        end
        ias_pkg::IAS_WR: begin
          if (rise) begin
            next_sh = {sh[6:0], sda_f};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == 4'h8) begin
            case (ptr)
              `IAS_REG_STR1, `IAS_REG_STR2, `IAS_REG_STR3, `IAS_REG_STR4: begin
                next_cur[ptr[1:0]] = sh[6:0]; // RULE11 RULE19
              end
              `IAS_REG_VREG: next_vreg = sh[6:0]; // RULE18
              `IAS_REG_HOLD: next_hold = sh[`IAS_HOLD_BIT]; // RULE21 RULE22
              default: ;
            endcase
            next_ptr = ptr_inc(ptr); // RULE11
            next_oe_n = 1'b0;
            next_state = ias_pkg::IAS_WR_ACK;
          end
        end
        ias_pkg::IAS_RD: begin
          if (rise) begin
            next_cnt = cnt + 4'h1;
          end else if (fall) begin
            if (cnt == 4'h8) begin
              next_oe_n = 1'b1;
              next_ptr = ptr_inc(ptr); // RULE13
              rd_clr = (ptr == `IAS_REG_FAULT); // RULE23
              next_state = ias_pkg::IAS_RD_ACK;
            end else begin
              next_sh = {sh[6:0], 1'b0};
              next_oe_n = sh[6]; // RULE6 RULE7
            end
          end
        end
        ias_pkg::IAS_RD_ACK: begin
          if (rise) begin
            next_mack = ~sda_f; // RULE8
          end else if (fall) begin
            if (mack) begin
              next_sh = rd_val;
              next_oe_n = rd_val[7];
              next_cnt = 4'h0;
              next_state = ias_pkg::IAS_RD;
            end else begin
              next_state = ias_pkg::IAS_IDLE;
            end
          end
        end
        default: begin
          next_state = ias_pkg::IAS_IDLE;
          next_oe_n = 1'b1;
        end
      endcase
    end
    // Converter results, ignored in standby
    if (adc_load && !hold) begin
      if (adc_chan == `IAS_ADC_CH_VOUT) begin
        next_vout = adc_data[6:0];
      end else if (adc_chan < `IAS_ADC_CH_VOUT) begin
        next_drn[adc_chan[1:0]] = adc_data; // RULE16 RULE17
      end
    end
    // Faults: cleared by a read or by entering standby, set wins
    next_fault = (rd_clr || (next_hold && !hold)) ? `IAS_RST6 : fault;
    next_fault = next_fault | (ev_now & ev_prev & {6{~hold}}); // RULE20 RULE23
  end

  // State and register file registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_prev <= 1'b1;
      d_prev <= 1'b1;
      state <= ias_pkg::IAS_IDLE;
      cnt <= 4'h0;
      sh <= `IAS_RST8;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
      ptr <= 4'h0;
      cur <= '{default: `IAS_RST7};
      vreg <= `IAS_RST7;
      vout <= `IAS_RST7;
      drn <= '{default: `IAS_RST8};
      fault <= `IAS_RST6;
      ev_prev <= `IAS_RST6;
      hold <= 1'b0;
    end else begin
      s_prev <= scl_f;
      d_prev <= sda_f;
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      rw <= next_rw;
      mack <= next_mack;
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
      ptr <= next_ptr;
      cur <= next_cur;
      vreg <= next_vreg;
      vout <= next_vout;
      drn <= next_drn;
      fault <= next_fault;
      ev_prev <= ev_now;
      hold <= next_hold;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence byte_end(ias_pkg::ias_state_t st);
    state == st && fall && !start_c && !stop_c && cnt == 4'h8;
  endsequence

  a_addr_ignore: assert property ( // RULE1
    byte_end(ias_pkg::IAS_ADDR) ##0 sh[7:1] != `IAS_SLAVE_ADDR |=> state == ias_pkg::IAS_IDLE)
    else $error("foreign address not ignored");
  a_addr_dir: assert property ( // RULE2
    byte_end(ias_pkg::IAS_ADDR) ##0 sh[7:1] == `IAS_SLAVE_ADDR
    |=> state == ias_pkg::IAS_ADDR_ACK && rw == $past(sh[0]))
    else $error("direction bit not taken from address byte");
  a_addr_ack: assert property ( // RULE4
    state == ias_pkg::IAS_ADDR_ACK |-> !sda_oe_n)
    else $error("address acknowledge not driven");
  a_cmd_refuse: assert property ( // RULE14
    byte_end(ias_pkg::IAS_CMD) ##0 (!cmd_ok(sh) || busy)
    |=> sda_oe_n && ptr == $past(ptr) && state == ias_pkg::IAS_IDLE)
    else $error("bad command acknowledged or pointer moved");
  a_wr_wrap: assert property ( // RULE11
    byte_end(ias_pkg::IAS_WR) ##0 ptr == `IAS_REG_LAST |=> ptr == 4'h0 && !sda_oe_n)
    else $error("write pointer did not wrap");
  a_rd_advance: assert property ( // RULE13
    byte_end(ias_pkg::IAS_RD) |=> ptr == ptr_inc($past(ptr)) && sda_oe_n)
    else $error("read pointer did not advance");
  a_msb_first: assert property ( // RULE6
    state == ias_pkg::IAS_ADDR_ACK && fall && rw && !start_c && !stop_c
    |=> sda_oe_n == $past(rd_val[7]) ##1 $stable(sda_oe_n) [*3])
    else $error("first read bit is not the msb");
  a_high_stable: assert property ( // RULE7
    state == ias_pkg::IAS_RD && scl_f && !start_c && !stop_c |=> $stable(sda_oe_n))
    else $error("data moved while clock high");
  a_fault_clear: assert property ( // RULE23
    byte_end(ias_pkg::IAS_RD) ##0 ptr == `IAS_REG_FAULT && !(|(ev_now & ev_prev))
    |=> fault == `IAS_RST6)
    else $error("fault register not cleared by read");
  a_hold_enter: assert property ( // RULE21
    byte_end(ias_pkg::IAS_WR) ##0 ptr == `IAS_REG_HOLD && sh[0] |=> low_power_hold)
    else $error("standby not entered");
endmodule

//--- sim/ias_bus_master.sv
// Behavioural two-wire bus master that drives the slave from the far side
`timescale 1ns/100ps
module ias_bus_master (
  // Bus lines, data open drain, enable low while pulling data low
  output logic scl,
  output logic sda_oe_n,
  // Resolved data line with pull-up
  input wire logic sda_line
);
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  // One clock pulse: long low so slave output settles before the rise
  task automatic bit_cycle(input logic v, output logic s);
    #50 sda_oe_n = v;
    #90 scl = 1'b1;
    #50 s = sda_line;
    #10 scl = 1'b0;
  endtask

  // Start or repeated start, data falls while clock high
  task automatic bus_start();
    #50 sda_oe_n = 1'b1;
    #100 scl = 1'b1;
    #100 sda_oe_n = 1'b0;
    #100 scl = 1'b0;
  endtask

  // Stop, data rises while clock high, bus left idle
  task automatic bus_stop();
    #50 sda_oe_n = 1'b0;
    #50 scl = 1'b1;
    #100 sda_oe_n = 1'b1;
    #100;
  endtask

  // Byte out, then release for the answer on the ninth clock
  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, ack_n);
  endtask

  // Byte in, then ack to continue or release on the last one
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      b[i] = s;
    end
    bit_cycle(last, s);
  endtask
endmodule

//--- sim/tb.sv
// Self-checking bench of the two-wire register access slave
`timescale 1ns/100ps
`include "ias_consts.svh"
module tb;
  logic mclk, rst, busy, adc_load, reg_overvolt_event, sda_out, sda_oe_n, m_oe_n, scl;
  logic low_power_hold, sda_line;
  logic [2:0] adc_chan;
  logic [7:0] adc_data;
  logic [3:0] string_short_event;
  logic [6:0] s1, s2, s3, s4, reg_set;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Open-drain data line with pull-up
  assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & m_oe_n;

  ias_slave dut_u (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .busy(busy), .adc_load(adc_load), .adc_chan(adc_chan),
    .adc_data(adc_data), .reg_overvolt_event(reg_overvolt_event),
    .string_short_event(string_short_event), .string1_current_setting(s1),
    .string2_current_setting(s2), .string3_current_setting(s3),
    .string4_current_setting(s4), .regulator_setting(reg_set),
    .low_power_hold(low_power_hold)
  );

  ias_bus_master master_u (.scl(scl), .sda_oe_n(m_oe_n), .sda_line(sda_line));

  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Byte to the slave, answer on the ninth clock compared
  task automatic send(input logic [7:0] b, input logic exp_ack_n);
    logic a;
    master_u.put_byte(b, a);
    chk({7'h00, exp_ack_n}, {7'h00, a});
  endtask

  task automatic reg_write(input logic [7:0] cmd, input logic [7:0] d);
    master_u.bus_start();
    send(8'hb0, 1'b0);
    send(cmd, 1'b0);
    send(d, 1'b0);
    master_u.bus_stop();
  endtask

  task automatic read_at(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] q;
    master_u.bus_start();
    send(8'hb0, 1'b0);
    send(cmd, 1'b0);
    master_u.bus_start();
    send(8'hb1, 1'b0);
    master_u.get_byte(1'b1, q);
    chk(exp, q);
    master_u.bus_stop();
  endtask

  // Read without a command, from the current pointer
  task automatic read_cur(input logic [7:0] exp);
    logic [7:0] q;
    master_u.bus_start();
    send(8'hb1, 1'b0);
    master_u.get_byte(1'b1, q);
    chk(exp, q);
    master_u.bus_stop();
  endtask

  task automatic adc_pulse(input logic [2:0] ch, input logic [7:0] d);
    @(negedge mclk);
    adc_load = 1'b1;
    adc_chan = ch;
    adc_data = d;
    @(negedge mclk);
    adc_load = 1'b0;
  endtask

  task automatic t_reset();
    chk({1'b0, s1}, 8'h00);
    chk({1'b0, s2}, 8'h00);
    chk({1'b0, s3}, 8'h00);
    chk({1'b0, s4}, 8'h00);
    chk({1'b0, reg_set}, 8'h00);
    chk({6'h00, low_power_hold, sda_oe_n}, 8'h01);
  endtask

  // Burst across the four string settings and the regulator setting in one transfer
  task automatic t_burst_write();
    master_u.bus_start();
    send(8'hb0, 1'b0);
    send(8'h00, 1'b0);
    for (int i = 1; i <= 5; i++) begin
      send(8'(8'h11 * i), 1'b0);
    end
    master_u.bus_stop();
    chk({1'b0, s1}, 8'h11);
    chk({1'b0, s2}, 8'h22);
    chk({1'b0, s3}, 8'h33);
    chk({1'b0, s4}, 8'h44);
    chk({1'b0, reg_set}, 8'h55);
  endtask

  task automatic t_wrong_addr();
    master_u.bus_start();
    send(8'ha0, 1'b1);
    master_u.bus_stop();
    master_u.bus_start();
    send(8'hb3, 1'b1);
    master_u.bus_stop();
  endtask

  // Read across the end of the map back to the first register
  task automatic t_wrap_read();
    logic [7:0] q;
    master_u.bus_start();
    send(8'hb0, 1'b0);
    send(8'h0c, 1'b0);
    master_u.bus_start();
    send(8'hb1, 1'b0);
    master_u.get_byte(1'b0, q);
    chk({5'h00, `IAS_REVISION}, q);
    master_u.get_byte(1'b1, q);
    chk(8'h11, q);
    master_u.bus_stop();
  endtask

  task automatic t_refused();
    master_u.bus_start();
    send(8'hb0, 1'b0);
    send(8'h0d, 1'b1);
    master_u.bus_stop();
    read_cur(8'h22);
    @(negedge mclk);
    busy = 1'b1;
    master_u.bus_start();
    send(8'hb0, 1'b0);
    send(8'h03, 1'b1);
    master_u.bus_stop();
    @(negedge mclk);
    busy = 1'b0;
    read_cur(8'h33);
  endtask

  task automatic t_adc();
    adc_pulse(3'h0, 8'h85);
    adc_pulse(3'h4, 8'hff);
    read_at(8'h05, 8'h85);
    read_at(8'h09, 8'h7f);
    reg_write(8'h05, 8'h00);
    read_at(8'h05, 8'h85);
  endtask

  // Single-cycle glitch ignored, longer events logged, read clears
  task automatic t_fault();
    @(negedge mclk);
    string_short_event = 4'h1;
    @(negedge mclk);
    string_short_event = 4'h0;
    reg_overvolt_event = 1'b1;
    string_short_event = 4'h2;
    repeat (3) @(negedge mclk);
    reg_overvolt_event = 1'b0;
    string_short_event = 4'h0;
    read_at(8'h0a, 8'h09);
    read_at(8'h0a, 8'h00);
  endtask

  task automatic t_standby();
    reg_write(8'h0b, 8'h01);
    chk({7'h00, low_power_hold}, 8'h01);
    adc_pulse(3'h1, 8'h12);
    read_at(8'h06, 8'h00);
    reg_write(8'h0b, 8'h00);
    chk({7'h00, low_power_hold}, 8'h00);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    busy = 1'b0;
    adc_load = 1'b0;
    adc_chan = 3'h0;
    adc_data = 8'h00;
    reg_overvolt_event = 1'b0;
    string_short_event = 4'h0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    t_reset();
    t_burst_write();
    t_wrong_addr();
    t_wrap_read();
    t_refused();
    t_adc();
    t_fault();
    t_standby();
    final_report();
  end
endmodule
